// *** rtl/spc_pkg.sv ***
// Package of constants and types for the self-program control block
package spc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SPC_CSR_OFF    = 8'h00;
  localparam logic [7:0] SPC_PTR_OFF    = 8'h04;
  localparam logic [7:0] SPC_DATA_OFF   = 8'h08;
  localparam logic [7:0] SPC_STROBE_OFF = 8'h0C;
  localparam logic [7:0] SPC_STATUS_OFF = 8'h10;
  localparam logic [7:0] SPC_CONFIG_OFF = 8'h14;
  localparam logic [7:0] SPC_BUFRD_OFF  = 8'h18;

  // ---------------------------------------------------------------
  // Control/status bit positions
  // ---------------------------------------------------------------
  localparam int SPC_IRQ_EN_BIT = 7;
  localparam int SPC_BUSY_BIT   = 6;
  localparam int SPC_SIG_BIT    = 5;
  localparam int SPC_REEN_BIT   = 4;
  localparam int SPC_LOCK_BIT   = 3;
  localparam int SPC_WRT_BIT    = 2;
  localparam int SPC_ERS_BIT    = 1;
  localparam int SPC_EN_BIT     = 0;

  // Accepted low-five-bit commands
  localparam logic [4:0] SPC_CMD_SIG  = 5'h11;
  localparam logic [4:0] SPC_CMD_REEN = 5'h11;
  localparam logic [4:0] SPC_CMD_LOCK = 5'h09;
  localparam logic [4:0] SPC_CMD_WRT  = 5'h05;
  localparam logic [4:0] SPC_CMD_ERS  = 5'h03;
  localparam logic [4:0] SPC_CMD_FILL = 5'h01;

  // ---------------------------------------------------------------
  // Geometry and timing
  // ---------------------------------------------------------------
  localparam int          SPC_PC_W       = 14;
  localparam int          SPC_WORD_W     = 6;
  localparam int          SPC_PAGE_W     = 8;
  localparam logic [13:0] SPC_NO_READ_WHILE_WRITE_SECTION_START = 14'h3800;
  localparam logic [13:0] SPC_BOOT_11    = 14'h3F00;
  localparam logic [13:0] SPC_BOOT_10    = 14'h3E00;
  localparam logic [13:0] SPC_BOOT_01    = 14'h3C00;
  localparam logic [13:0] SPC_BOOT_00    = 14'h3800;
  localparam logic [2:0]  SPC_ST_WIN     = 3'h4;
  localparam logic [2:0]  SPC_LD_WIN     = 3'h3;
  localparam logic [7:0]  SPC_CSR_RST    = 8'h00;
  localparam logic [15:0] SPC_OP_CYC     = 16'h0100;

  typedef enum logic [2:0] {SPC_IDLE, SPC_ARMED, SPC_PROG} spc_state_e;
  typedef enum logic [2:0] {SPC_K_FILL, SPC_K_ERS, SPC_K_WRT, SPC_K_LOCK,
                            SPC_K_REEN, SPC_K_SIG} spc_kind_e;

endpackage

// *** rtl/spc_top.sv ***
// Self-program control sequencer with AHB-Lite register slave
//
// Operation
// - Boot size sets boot start address
// - Below 0x3800 read-while-write, else not
// - 14-bit counter, 64-word pages
// - Page from pointer 14:7, word 6:1
// - Pointer bit 0 selects load byte
// - Ready request while enabled and store-enable clear
// - Section busy set by read-while-write section erase/write
// - Busy cleared by re-enable or buffer fill
// - Signature read: load returns signature, store ignored
// - Re-enable store, refused during programming
// - Re-enable during fill discards buffer
// - Lock set from low data register
// - Lock-set load returns lock or fuse
// - Page write from buffer, auto-clear
// - Page erase, auto-clear
// - Halt core for no-read-while-write programming
// - Store-enable alone fills buffer word
// - Four-cycle arming, held during programming
// - Only five patterns accepted
`timescale 1ns/1ns
`default_nettype none

module spc_top
  import spc_pkg::*;
#(
  parameter logic [15:0] OP_CYC   = SPC_OP_CYC,
  parameter logic [7:0]  FUSE_VAL = 8'hFF,
  parameter logic [7:0]  SIG_VAL  = 8'h5A  // Arbitrary signature value
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        global_irq_flag,
  output logic             ready_irq,
  output logic             core_halt,
  output logic             section_busy_flag
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                   wr_pend;
    logic [7:0]             addr;
    logic [31:0]            rdata;
    logic [7:0]             csr;
    logic [15:0]            ptr;
    logic [15:0]            data;
    logic [1:0]             boot_size;
    logic [2:0]             win;
    logic [15:0]            op_cnt;
    spc_state_e             state;
    spc_kind_e              kind;
    logic                   filling;
    logic [7:0]             lock;
    logic [7:0]             load_byte;
    logic                   load_ok;
    logic [7:0]             last_page;
    logic [SPC_WORD_W-1:0]  bufidx;
    logic [15:0]            bufword;
  } spc_state_s;

  spc_state_s cur_ff;
  spc_state_s nxt_cur;

  logic [15:0] buf_ff [64];
  logic        buf_we;
  logic        buf_clr;

  // ---------------------------------------------------------------
  // Combinational decode
  // ---------------------------------------------------------------
  logic        acc;
  logic [13:0] boot_start;
  logic [7:0]  page_sel;
  logic [5:0]  word_sel;
  logic        no_read_while_write_section_page;
  logic [4:0]  cmd;
  logic        cmd_ok;

  assign acc = hsel && hready && htrans[1];
  assign page_sel = cur_ff.ptr[14:7];
  assign word_sel = cur_ff.ptr[6:1];
  assign no_read_while_write_section_page = ({page_sel, 6'h00} >= SPC_NO_READ_WHILE_WRITE_SECTION_START);

  always_comb
  begin
    unique case (cur_ff.boot_size)
      2'b11: boot_start = SPC_BOOT_11;
      2'b10: boot_start = SPC_BOOT_10;
      2'b01: boot_start = SPC_BOOT_01;
      default: boot_start = SPC_BOOT_00;
    endcase
  end

  assign cmd = hwdata[4:0];
  assign cmd_ok = (cmd == SPC_CMD_REEN) || (cmd == SPC_CMD_LOCK)
               || (cmd == SPC_CMD_WRT) || (cmd == SPC_CMD_ERS)
               || (cmd == SPC_CMD_FILL);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    buf_we = 1'b0;
    buf_clr = 1'b0;
    nxt_cur.wr_pend = acc && hwrite;
    if (acc)
    begin
      nxt_cur.addr = haddr[7:0];
    end
    // Arming window runs down from the control write
    if (cur_ff.state == SPC_ARMED)
    begin
      if (cur_ff.win == 3'h1)
      begin
        nxt_cur.state = SPC_IDLE;
        nxt_cur.csr[5:0] = 6'h00;
        nxt_cur.load_ok = 1'b0;
      end
      nxt_cur.win = cur_ff.win - 3'h1;
      if (cur_ff.win <= (SPC_ST_WIN - SPC_LD_WIN + 3'h1))
      begin
        nxt_cur.load_ok = 1'b0;
      end
    end
    if (cur_ff.state == SPC_PROG)
    begin
      if (cur_ff.op_cnt == 16'h0001)
      begin
        nxt_cur.state = SPC_IDLE;
        nxt_cur.csr[5:0] = 6'h00;
      end
      nxt_cur.op_cnt = cur_ff.op_cnt - 16'h0001;
    end
    if (cur_ff.wr_pend)
    begin
      unique case (cur_ff.addr)
        SPC_CSR_OFF:
        begin
          nxt_cur.csr[SPC_IRQ_EN_BIT] = hwdata[SPC_IRQ_EN_BIT];
          if (hwdata[SPC_REEN_BIT] && cur_ff.filling)
          begin
            buf_clr = 1'b1;
            nxt_cur.filling = 1'b0;
          end
          if (cur_ff.state != SPC_PROG && cmd_ok)
          begin
            nxt_cur.csr[5:0] = hwdata[5:0];
            nxt_cur.state = SPC_ARMED;
            nxt_cur.win = SPC_ST_WIN;
            nxt_cur.load_ok = hwdata[SPC_SIG_BIT] || hwdata[SPC_LOCK_BIT];
            nxt_cur.kind = hwdata[SPC_SIG_BIT]  ? SPC_K_SIG  :
                           hwdata[SPC_REEN_BIT] ? SPC_K_REEN :
                           hwdata[SPC_LOCK_BIT] ? SPC_K_LOCK :
                           hwdata[SPC_WRT_BIT]  ? SPC_K_WRT  :
                           hwdata[SPC_ERS_BIT]  ? SPC_K_ERS  : SPC_K_FILL;
          end
        end
        SPC_PTR_OFF:  nxt_cur.ptr = hwdata[15:0];
        SPC_DATA_OFF: nxt_cur.data = hwdata[15:0];
        SPC_CONFIG_OFF: nxt_cur.boot_size = hwdata[1:0];
        SPC_STROBE_OFF:
        begin
          // Bit 0 is a store instruction, bit 1 a load instruction
          if (hwdata[0] && cur_ff.state == SPC_ARMED)
          begin
            nxt_cur.state = SPC_IDLE;
            nxt_cur.csr[5:0] = 6'h00;
            nxt_cur.load_ok = 1'b0;
            unique case (cur_ff.kind)
              SPC_K_FILL:
              begin
                buf_we = 1'b1;
                nxt_cur.filling = 1'b1;
                nxt_cur.csr[SPC_BUSY_BIT] = 1'b0;
              end
              SPC_K_REEN:
              begin
                nxt_cur.csr[SPC_BUSY_BIT] = 1'b0;
              end
              SPC_K_LOCK: nxt_cur.lock = cur_ff.data[7:0];
              SPC_K_SIG: ;
              default:
              begin
                nxt_cur.state = SPC_PROG;
                nxt_cur.csr[5:0] = cur_ff.csr[5:0];
                nxt_cur.op_cnt = OP_CYC;
                nxt_cur.last_page = page_sel;
                if (!no_read_while_write_section_page)
                begin
                  nxt_cur.csr[SPC_BUSY_BIT] = 1'b1;
                end
                if (cur_ff.kind == SPC_K_WRT)
                begin
                  buf_clr = 1'b1;
                  nxt_cur.filling = 1'b0;
                end
              end
            endcase
          end
          if (hwdata[1] && cur_ff.load_ok)
          begin
            nxt_cur.load_ok = 1'b0;
            nxt_cur.state = SPC_IDLE;
            nxt_cur.csr[5:0] = 6'h00;
            nxt_cur.load_byte = (cur_ff.kind == SPC_K_SIG) ? SIG_VAL :
                                cur_ff.ptr[0] ? FUSE_VAL : cur_ff.lock;
          end
        end
        SPC_BUFRD_OFF: nxt_cur.bufidx = hwdata[5:0];
        default: ;
      endcase
    end
    nxt_cur.bufword = buf_ff[cur_ff.bufidx];
    // Read data is latched at the address phase so it stands in the data phase
    if (acc && !hwrite)
    begin
      unique case (haddr[7:0])
        SPC_CSR_OFF:    nxt_cur.rdata = {24'h000000, cur_ff.csr};
        SPC_PTR_OFF:    nxt_cur.rdata = {16'h0000, cur_ff.ptr};
        SPC_DATA_OFF:   nxt_cur.rdata = {16'h0000, cur_ff.data};
        SPC_STATUS_OFF: nxt_cur.rdata = {2'h0, boot_start, cur_ff.last_page,
                                         cur_ff.load_byte};
        SPC_CONFIG_OFF: nxt_cur.rdata = {30'h0, cur_ff.boot_size};
        SPC_BUFRD_OFF:  nxt_cur.rdata = {16'h0000, cur_ff.bufword};
        default:        nxt_cur.rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_ff <= '0;
      cur_ff.lock <= 8'hFF;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // Page buffer: 64 words, pointer bit 0 ignored on fill
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 64; i++)
      begin
        buf_ff[i] <= 16'hFFFF;
      end
    end
    else if (buf_clr)
    begin
      for (int i = 0; i < 64; i++)
      begin
        buf_ff[i] <= 16'hFFFF;
      end
    end
    else if (buf_we)
    begin
      buf_ff[word_sel] <= cur_ff.data;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata = cur_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign section_busy_flag = cur_ff.csr[SPC_BUSY_BIT];
  assign ready_irq = cur_ff.csr[SPC_IRQ_EN_BIT] && global_irq_flag
                   && !cur_ff.csr[SPC_EN_BIT];
  assign core_halt = (cur_ff.state == SPC_PROG) && (cur_ff.last_page >= 8'hE0);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_irq;
    @(posedge clk) disable iff (!rst_b)
    ready_irq == (cur_ff.csr[7] && global_irq_flag && !cur_ff.csr[0]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_win;
    @(posedge clk) disable iff (!rst_b)
    (cur_ff.state == SPC_ARMED && cur_ff.win == 3'h4) ##1
    (cur_ff.state == SPC_ARMED)[*3] |=> cur_ff.state != SPC_ARMED;
  endproperty
  a_win: assert property (p_win) else $error("window overrun");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
    cur_ff.state == SPC_PROG |-> cur_ff.csr[0];
  endproperty
  a_hold: assert property (p_hold) else $error("enable dropped");

  property p_halt;
    @(posedge clk) disable iff (!rst_b)
    core_halt |-> cur_ff.state == SPC_PROG && !$rose(section_busy_flag);
  endproperty
  a_halt: assert property (p_halt) else $error("bad halt");

  property p_busy;
    @(posedge clk) disable iff (!rst_b)
    $rose(section_busy_flag) |-> cur_ff.state == SPC_PROG && cur_ff.last_page < 8'hE0;
  endproperty
  a_busy: assert property (p_busy) else $error("busy set wrongly");

  property p_fill_clr;
    @(posedge clk) disable iff (!rst_b)
    buf_we |=> !section_busy_flag;
  endproperty
  a_fill_clr: assert property (p_fill_clr) else $error("busy kept");

  property p_idle_zero;
    @(posedge clk) disable iff (!rst_b)
    cur_ff.state == SPC_IDLE |-> cur_ff.csr[5:0] == 6'h00 || $past(cur_ff.wr_pend);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("bits stuck");

  property p_prog_len;
    @(posedge clk) disable iff (!rst_b)
    cur_ff.state == SPC_PROG |-> cur_ff.op_cnt <= OP_CYC;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("count overrun");

  property p_load_win;
    @(posedge clk) disable iff (!rst_b)
    cur_ff.load_ok |-> cur_ff.state == SPC_ARMED && cur_ff.win >= 3'h2;
  endproperty
  a_load_win: assert property (p_load_win) else $error("load window overrun");

  property p_prog_locked;
    @(posedge clk) disable iff (!rst_b)
    cur_ff.state == SPC_PROG && cur_ff.op_cnt != 16'h0001 |=> $stable(cur_ff.csr[5:0]);
  endproperty
  a_prog_locked: assert property (p_prog_locked) else $error("command taken while busy");

  property p_busy_keep;
    @(posedge clk) disable iff (!rst_b)
    section_busy_flag && cur_ff.state == SPC_PROG |=> section_busy_flag;
  endproperty
  a_busy_keep: assert property (p_busy_keep) else $error("busy lost");

  c_fill: cover property (@(posedge clk) disable iff (!rst_b) buf_we);
  c_prog: cover property (@(posedge clk) disable iff (!rst_b) cur_ff.state == SPC_PROG);
  c_halt: cover property (@(posedge clk) disable iff (!rst_b) core_halt);
  c_load: cover property (@(posedge clk) disable iff (!rst_b) cur_ff.load_ok);

endmodule

`default_nettype wire

// *** verif/self_program_control_tb.sv ***
// Self-checking testbench of the self-program control block
`timescale 1ns/1ns
`default_nettype none

module self_program_control_tb import spc_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_b;
  logic        global_irq_flag;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ready_irq;
  logic        core_halt;
  logic        section_busy_flag;
  int          errors = 0;
  int          compares = 0;
  logic [13:0] boot [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
  logic [4:0]  bad [4] = '{5'h07, 5'h19, 5'h0F, 5'h1F};

  always #2 clk = ~clk;

  spc_top #(.OP_CYC(16'h0008), .FUSE_VAL(8'hA5), .SIG_VAL(8'h3C)) u_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_irq_flag(global_irq_flag), .ready_irq(ready_irq),
    .core_halt(core_halt), .section_busy_flag(section_busy_flag)
  );

  spc_core_model u_core (
    .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_core.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e,
                    input logic [31:0] m);
    logic [31:0] q;
    u_core.xfer(1'b0, a, 32'h0, q);
    chk(n, e & m, q & m);
  endtask

  task automatic cmd(input logic [15:0] z, input logic [7:0] c, input logic [1:0] st);
    wr(SPC_PTR_OFF, {16'h0, z});
    wr(SPC_CSR_OFF, {24'h0, c});
    wr(SPC_STROBE_OFF, {30'h0, st});
  endtask

  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #20000;
    errors++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] a;
    logic [31:0] b;
    rst_b = 1'b0;
    global_irq_flag = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(SPC_CSR_OFF, "csr reset", 32'h0, 32'hFF);
    chk("busy reset", 32'h0, {31'h0, section_busy_flag});
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      wr(SPC_CONFIG_OFF, i);
      rd(SPC_STATUS_OFF, "boot start", {2'h0, boot[i], 16'h0}, 32'h3FFF0000);
    end
    $display("test boot size done");
    wr(SPC_DATA_OFF, 32'h1234);
    cmd(16'h000A, 8'h01, 2'h1);
    wr(SPC_DATA_OFF, 32'hBEEF);
    cmd(16'h007E, 8'h01, 2'h1);
    rd(SPC_CSR_OFF, "store enable after fill", 32'h0, 32'h01);
    wr(SPC_DATA_OFF, 32'h0);
    wr(SPC_CSR_OFF, 32'h01);
    repeat (6) @(posedge clk);
    wr(SPC_STROBE_OFF, 32'h1);
    rd(SPC_CSR_OFF, "store enable expired", 32'h0, 32'h01);
    wr(SPC_BUFRD_OFF, 32'd5);
    rd(SPC_BUFRD_OFF, "buffer word 5", 32'h1234, 32'hFFFF);
    wr(SPC_BUFRD_OFF, 32'd63);
    rd(SPC_BUFRD_OFF, "buffer word 63", 32'hBEEF, 32'hFFFF);
    $display("test fill done");
    foreach (bad[i])
    begin
      wr(SPC_CSR_OFF, {27'h0, bad[i]});
      rd(SPC_CSR_OFF, "invalid pattern", 32'h0, 32'h3F);
    end
    $display("test patterns done");
    cmd(16'h0800, 8'h03, 2'h1);
    @(posedge clk);
    chk("busy on erase", 32'h1, {31'h0, section_busy_flag});
    chk("halt on rww erase", 32'h0, {31'h0, core_halt});
    rd(SPC_CSR_OFF, "enable held", 32'h01, 32'h01);
    wr(SPC_CSR_OFF, 32'h11);
    wr(SPC_STROBE_OFF, 32'h1);
    repeat (16) @(posedge clk);
    rd(SPC_CSR_OFF, "erase cleared", 32'h40, 32'h7F);
    rd(SPC_STATUS_OFF, "erase page", 32'h1000, 32'hFF00);
    cmd(16'h0000, 8'h11, 2'h1);
    @(posedge clk);
    chk("busy after reenable", 32'h0, {31'h0, section_busy_flag});
    cmd(16'h0080, 8'h03, 2'h1);
    repeat (16) @(posedge clk);
    cmd(16'h0000, 8'h01, 2'h1);
    @(posedge clk);
    chk("busy after fill", 32'h0, {31'h0, section_busy_flag});
    cmd(16'hF000, 8'h05, 2'h1);
    @(posedge clk);
    chk("halt on no_read_while_write_section write", 32'h1, {31'h0, core_halt});
    chk("busy on no_read_while_write_section write", 32'h0, {31'h0, section_busy_flag});
    repeat (16) @(posedge clk);
    chk("halt released", 32'h0, {31'h0, core_halt});
    rd(SPC_CSR_OFF, "write cleared", 32'h0, 32'h07);
    rd(SPC_STATUS_OFF, "write page", 32'hE000, 32'hFF00);
    $display("test programming done");
    global_irq_flag <= 1'b1;
    wr(SPC_CSR_OFF, 32'h80);
    @(posedge clk);
    chk("ready irq", 32'h1, {31'h0, ready_irq});
    wr(SPC_CSR_OFF, 32'h81);
    @(posedge clk);
    chk("ready irq armed", 32'h0, {31'h0, ready_irq});
    repeat (8) @(posedge clk);
    chk("ready irq again", 32'h1, {31'h0, ready_irq});
    global_irq_flag <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk("ready irq global off", 32'h0, {31'h0, ready_irq});
    $display("test ready irq done");
    wr(SPC_DATA_OFF, 32'hFFC3);
    cmd(16'h0000, 8'h09, 2'h1);
    repeat (16) @(posedge clk);
    rd(SPC_CSR_OFF, "lock bit cleared", 32'h0, 32'h09);
    cmd(16'h0001, 8'h09, 2'h2);
    u_core.xfer(1'b0, SPC_STATUS_OFF, 32'h0, a);
    cmd(16'h0000, 8'h09, 2'h2);
    u_core.xfer(1'b0, SPC_STATUS_OFF, 32'h0, b);
    chk("lock and fuse", 32'h1, {31'h0, (a[7:0] === 8'hC3 && b[7:0] === 8'hA5) ||
        (a[7:0] === 8'hA5 && b[7:0] === 8'hC3)});
    cmd(16'h0000, 8'h21, 2'h2);
    rd(SPC_STATUS_OFF, "signature", 32'h3C, 32'hFF);
    wr(SPC_CSR_OFF, 32'h09);
    @(posedge clk);
    wr(SPC_STROBE_OFF, 32'h2);
    rd(SPC_STATUS_OFF, "late load", 32'h3C, 32'hFF);
    $display("test lock and signature done");
    give_verdict();
  end
endmodule

`default_nettype wire

// *** verif/spc_core_model.sv ***
// Processor core model issuing register and strobe accesses over AHB-Lite
`timescale 1ns/1ns
`default_nettype none

module spc_core_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; released write data is inverted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

`default_nettype wire
